/* File: hdl/ics_pkg.sv */
// Constants and types shared by both ends of the interrupt command link.
// Assumes one 125 MHz clock and an active-low asynchronous reset.
package ics_pkg;

	// Command register field positions.
	localparam int VEC_LSB = 0;
	localparam int MODE_LSB = 8;
	localparam int DMODE_BIT = 11;
	localparam int STATUS_BIT = 12;
	localparam int LEVEL_BIT = 14;
	localparam int TRIG_BIT = 15;
	localparam int SHORT_LSB = 18;
	localparam int DEST_LSB = 56;

	// Mask of software-writable bits in the low half.
	localparam logic [31:0] LOW_WMASK = 32'h000CCFFF;
	localparam logic [31:0] HIGH_WMASK = 32'hFF000000;
	localparam logic [63:0] CMD_RESET = 64'h0000000000000000;

	// Register port word addresses.
	localparam logic [1:0] ADDR_LOW = 2'h0;
	localparam logic [1:0] ADDR_HIGH = 2'h1;
	localparam logic [1:0] ADDR_SELF = 2'h2;

	// Acceptance answer window in cycles.
	localparam logic [7:0] ACCEPT_DELAY = 8'h04;

	typedef enum logic [2:0] {
		ICS_FIXED = 3'b000,
		ICS_LOWEST = 3'b001,
		ICS_SYSMGT = 3'b010,
		ICS_RESV = 3'b011,
		ICS_NMI = 3'b100,
		ICS_INIT = 3'b101,
		ICS_START = 3'b110,
		ICS_RESV7 = 3'b111
	} ics_mode_t;

	typedef enum logic [1:0] {
		ICS_SH_DEST = 2'b00,
		ICS_SH_SELF = 2'b01,
		ICS_SH_ALL = 2'b10,
		ICS_SH_OTHERS = 2'b11
	} ics_short_t;

	// One message as it travels across the system bus.
	typedef struct packed {
		ics_mode_t mode;
		logic [7:0] vector;
		logic dest_logical;
		logic level;
		logic trigger;
		ics_short_t shorthand;
		logic [7:0] dest;
		logic [7:0] source;
		logic sync;
	} ics_msg_t;

endpackage : ics_pkg

/* File: hdl/ics_link_if.sv */
// Interface joining the sender and a remote receiving unit.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface ics_link_if;
	ics_pkg::ics_msg_t msg;
	logic msg_valid;
	logic accept;

	modport sender (output msg, output msg_valid, input accept);
	modport receiver (input msg, input msg_valid, output accept);
endinterface : ics_link_if
`default_nettype wire

/* File: hdl/ics_sender.sv */
// Command register and send logic of a local interrupt unit.
// Assumes the receiver answers each message with one accept pulse.
//
// How it works
// [R1] Sixty-four bit command register held here.
// [R2] Writing low half launches the message; a write while msg_valid is still high only stores.
// [R3] All fields writable except delivery status.
// [R4] Vector field sent with the message.
// [R5] Mode 000 delivers vector to all targets.
// [R6] Mode 001 lowest priority, else like fixed.
// [R7] Mode 010 sends system management; vector 00H.
// [R8] Mode 100 sends non-maskable, vector dropped.
// [R9] Mode 101 assert sends init; vector 00H.
// [R10] Init de-assert broadcasts arbitration sync.
// [R11] Software clears level, sets trigger first.
// [R12] Sync goes to all, ignoring destinations.
// [R13] Software should still pick all-including-self.
// [R14] Status reads 1 until targets accept.
// [R15] Destination mode: physical 0, logical 1.
// [R16] Shorthand codes: field, self, all, others.
// [R17] Trigger bit matters only for de-assert.
// [R18] High-half write never launches anything.
// [R19] Reserved mode 011 sends no message.
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ics_sender (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic [1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] i_self_id,
	output logic [31:0] o_rdata,
	output logic o_busy,
	ics_link_if.sender link
);

	typedef struct packed {
		logic [63:0] cmd;
		logic pending;
		logic [31:0] rdata;
		ics_pkg::ics_msg_t msg;
		logic msg_valid;
	} ics_snd_state_t;

	ics_snd_state_t st;
	ics_snd_state_t next_st;
	ics_pkg::ics_mode_t mode;
	logic deassert;

	always_comb begin
		next_st = st;
		next_st.msg_valid = 1'b0;
		mode = ics_pkg::ics_mode_t'(st.cmd[ics_pkg::MODE_LSB +: 3]);
		deassert = (mode == ics_pkg::ICS_INIT) &&
			!st.cmd[ics_pkg::LEVEL_BIT];
		// [R14] Acceptance clears pending.
		if (link.accept) begin
			next_st.pending = 1'b0;
		end
		// [R18] High half stores only.
		if (i_wr && i_addr == ics_pkg::ADDR_HIGH) begin
			next_st.cmd[63:32] = i_wdata & ics_pkg::HIGH_WMASK;
		end
		// [R2] Low-half write launches unless msg_valid is still set.
		if (i_wr && i_addr == ics_pkg::ADDR_LOW) begin
			// [R3] Status bit kept read only.
			next_st.cmd[31:0] = i_wdata & ics_pkg::LOW_WMASK;
		end
		// Launch uses the freshly written low half.
		if (st.msg_valid == 1'b0 && i_wr && i_addr == ics_pkg::ADDR_LOW) begin
			mode = ics_pkg::ics_mode_t'(i_wdata[ics_pkg::MODE_LSB +: 3]);
			deassert = (mode == ics_pkg::ICS_INIT) &&
				!i_wdata[ics_pkg::LEVEL_BIT];
			// [R4] Vector carried along.
			next_st.msg.vector = i_wdata[7:0];
			next_st.msg.mode = mode;
			// [R15] Destination mode passed.
			next_st.msg.dest_logical = i_wdata[ics_pkg::DMODE_BIT];
			next_st.msg.level = i_wdata[ics_pkg::LEVEL_BIT];
			// [R17] Trigger only for de-assert.
			next_st.msg.trigger = deassert & i_wdata[ics_pkg::TRIG_BIT];
			// [R16] Shorthand passed through.
			next_st.msg.shorthand =
				ics_pkg::ics_short_t'(i_wdata[ics_pkg::SHORT_LSB +: 2]);
			next_st.msg.dest = st.cmd[ics_pkg::DEST_LSB +: 8];
			next_st.msg.source = i_self_id;
			next_st.msg.sync = deassert;
			next_st.msg_valid = 1'b1;
			case (mode)
				// [R5] Fixed delivery.
				ics_pkg::ICS_FIXED: begin
				end
				// [R6] Lowest priority delivery.
				ics_pkg::ICS_LOWEST: begin
				end
				// [R7] System management interrupt.
				ics_pkg::ICS_SYSMGT: begin
					next_st.msg.vector = 8'h00;
				end
				// [R8] Vector disregarded.
				ics_pkg::ICS_NMI: begin
					next_st.msg.vector = 8'h00;
				end
				// [R9] Init assert; [R10] de-assert sync.
				ics_pkg::ICS_INIT: begin
					next_st.msg.vector = 8'h00;
					if (deassert) begin
						// [R12] Broadcast to all.
						next_st.msg.shorthand = ics_pkg::ICS_SH_ALL;
						next_st.msg.dest = 8'hFF;
						next_st.msg.dest_logical = 1'b0;
					end
				end
				ics_pkg::ICS_START: begin
				end
				// [R19] Reserved sends nothing.
				default: begin
					next_st.msg_valid = 1'b0;
				end
			endcase
			// [R14] Pending set wins over accept.
			if (next_st.msg_valid) begin
				next_st.pending = 1'b1;
			end
		end
		next_st.rdata = 32'h00000000;
		if (i_rd) begin
			case (i_addr)
				ics_pkg::ADDR_LOW: begin
					next_st.rdata = st.cmd[31:0];
					next_st.rdata[ics_pkg::STATUS_BIT] = st.pending;
				end
				ics_pkg::ADDR_HIGH: begin
					next_st.rdata = st.cmd[63:32];
				end
				default: begin
					next_st.rdata = 32'h00000000;
				end
			endcase
		end
	end

	// [R1] Command register storage.
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_rdata = st.rdata;
	assign o_busy = st.pending;
	assign link.msg = st.msg;
	assign link.msg_valid = st.msg_valid;

endmodule : ics_sender
`default_nettype wire

/* File: hdl/ics_receiver.sv */
// Remote receiving unit: decodes messages and accepts them.
// Assumes messages arrive as one-cycle valid pulses from the sender.
`timescale 1ns/1ps
`default_nettype none
module ics_receiver (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic [7:0] i_unit_id,
	ics_link_if.receiver link,
	output logic o_fixed,
	output logic o_sysmgt,
	output logic o_nmi,
	output logic o_init,
	output logic o_startup,
	output logic [7:0] o_vector,
	output logic [7:0] o_arbitration_identifier
);

	typedef struct packed {
		logic [7:0] count;
		logic accept;
		logic fixed;
		logic sysmgt;
		logic nmi;
		logic init;
		logic startup;
		logic [7:0] vector;
		logic [7:0] arbitration_identifier;
	} ics_rcv_state_t;

	ics_rcv_state_t st;
	ics_rcv_state_t next_st;

	always_comb begin
		next_st = st;
		next_st.accept = 1'b0;
		next_st.fixed = 1'b0;
		next_st.sysmgt = 1'b0;
		next_st.nmi = 1'b0;
		next_st.init = 1'b0;
		next_st.startup = 1'b0;
		if (st.count != 8'h00) begin
			next_st.count = st.count - 8'h01;
			next_st.accept = (st.count == 8'h01);
		end
		if (link.msg_valid) begin
			next_st.count = ics_pkg::ACCEPT_DELAY;
			next_st.vector = link.msg.vector;
			if (link.msg.sync) begin
				// [R10] Arbitration id reload.
				next_st.arbitration_identifier = i_unit_id;
			end else begin
				case (link.msg.mode)
					ics_pkg::ICS_FIXED: next_st.fixed = 1'b1;
					ics_pkg::ICS_LOWEST: next_st.fixed = 1'b1;
					ics_pkg::ICS_SYSMGT: next_st.sysmgt = 1'b1;
					ics_pkg::ICS_NMI: next_st.nmi = 1'b1;
					ics_pkg::ICS_INIT: next_st.init = 1'b1;
					ics_pkg::ICS_START: next_st.startup = 1'b1;
					default: next_st.fixed = 1'b0;
				endcase
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign link.accept = st.accept;
	assign o_fixed = st.fixed;
	assign o_sysmgt = st.sysmgt;
	assign o_nmi = st.nmi;
	assign o_init = st.init;
	assign o_startup = st.startup;
	assign o_vector = st.vector;
	assign o_arbitration_identifier = st.arbitration_identifier;

endmodule : ics_receiver
`default_nettype wire

/* File: tb/ics_link_chk.sv */
// Assertions on the link between the sender and the receiver.
// Assumes it sees the link signals beside one clock and reset.
`timescale 1ns/1ps
`default_nettype none
module ics_link_chk (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire ics_pkg::ics_msg_t msg,
	input wire logic msg_valid,
	input wire logic accept
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	AST_ONE_SHOT: assert property (msg_valid |=> !msg_valid)
		else $error("Message valid held too long.");
	AST_ACCEPT_TIME: assert property (
		msg_valid ##1 (!msg_valid) [*4] |=> accept)
		else $error("Accept missing five cycles after message.");
	AST_ACCEPT_CAUSE: assert property (
		accept |-> $past(msg_valid, 5))
		else $error("Accept without message five cycles before.");
	AST_VEC_ZERO: assert property (msg_valid && (msg.mode inside
		{ics_pkg::ICS_SYSMGT, ics_pkg::ICS_NMI, ics_pkg::ICS_INIT})
		|-> msg.vector == 8'h00)
		else $error("Vector not cleared for this mode.");
	AST_NO_RESV: assert property (msg_valid |-> !(msg.mode inside
		{ics_pkg::ICS_RESV, ics_pkg::ICS_RESV7}))
		else $error("Reserved mode was sent.");
	AST_SYNC_ALL: assert property (msg_valid && msg.sync |->
		msg.shorthand == ics_pkg::ICS_SH_ALL && msg.dest == 8'hFF)
		else $error("Sync message not sent to all.");
	AST_SYNC_MODE: assert property (msg_valid && msg.sync |->
		msg.mode == ics_pkg::ICS_INIT && !msg.level)
		else $error("Sync message with wrong mode or level.");
	AST_TRIG_ZERO: assert property (
		msg_valid && !msg.sync |-> !msg.trigger)
		else $error("Trigger sent outside sync message.");
endmodule : ics_link_chk
`default_nettype wire

/* File: tb/tb_ipi_command_sender.sv */
// Bench joining the sender and the receiver through the link.
// Assumes the register port and link timing of the design.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
	$display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_ipi_command_sender;
	logic i_clock = 1'b0;
	logic i_nrst = 1'b0;
	logic [1:0] i_addr = 2'h0;
	logic [31:0] i_wdata = 32'h00000000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [31:0] o_rdata;
	logic o_busy;
	logic [4:0] pulse;
	logic [7:0] o_vector;
	logic [7:0] o_arbitration_identifier;
	int num_errors = 0;
	int checks = 0;
	int cyc = 0;
	localparam logic [2:0] MODES [7] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5,
		3'h5, 3'h6};
	localparam logic [4:0] PULSES [7] = '{5'h10, 5'h10, 5'h08, 5'h04,
		5'h02, 5'h00, 5'h01};
	ics_link_if ics_link_if_inst ();
	ics_sender ics_sender_inst (.i_clock(i_clock), .i_nrst(i_nrst),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.i_self_id(8'h21), .o_rdata(o_rdata), .o_busy(o_busy),
		.link(ics_link_if_inst.sender));
	ics_receiver ics_receiver_inst (.i_clock(i_clock), .i_nrst(i_nrst),
		.i_unit_id(8'h3C), .link(ics_link_if_inst.receiver),
		.o_fixed(pulse[4]), .o_sysmgt(pulse[3]), .o_nmi(pulse[2]),
		.o_init(pulse[1]), .o_startup(pulse[0]), .o_vector(o_vector),
		.o_arbitration_identifier(o_arbitration_identifier));
	ics_link_chk ics_link_chk_inst (.i_clock(i_clock), .i_nrst(i_nrst),
		.msg(ics_link_if_inst.msg), .msg_valid(ics_link_if_inst.msg_valid),
		.accept(ics_link_if_inst.accept));
	always #4 i_clock = ~i_clock;
	always @(posedge i_clock) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("Checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	task automatic wr(input logic [1:0] a, input logic [31:0] d);
		@(posedge i_clock);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clock);
		i_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [1:0] a, input logic [31:0] e,
		input string n);
		@(posedge i_clock);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1;
		`CHK(n, e, o_rdata)
	endtask : rd
	initial begin
		logic [2:0] m;
		logic [31:0] d;
		logic s;
		logic [7:0] v;
		int w;
		repeat (3) @(posedge i_clock);
		i_nrst <= 1'b1;
		rd(ics_pkg::ADDR_LOW, ics_pkg::CMD_RESET[31:0], "low rst");
		rd(ics_pkg::ADDR_HIGH, 32'h00000000, "high rst");
		wr(ics_pkg::ADDR_HIGH, 32'hFFFFFFFF);
		`CHK("high", 1'b0, ics_link_if_inst.msg_valid)
		rd(ics_pkg::ADDR_HIGH, ics_pkg::HIGH_WMASK, "high rd");
		wr(ics_pkg::ADDR_HIGH, 32'hAB000000);
		wr(ics_pkg::ADDR_LOW, 32'hFFFFFBFF);
		`CHK("resv", 1'b0, ics_link_if_inst.msg_valid)
		rd(ics_pkg::ADDR_LOW, 32'h000CCBFF, "low rd");
		rd(ics_pkg::ADDR_SELF, 32'h00000000, "unmapped");
		for (int i = 0; i < 7; i++) begin
			m = MODES[i];
			s = (i == 5);
			v = (m inside {3'h2, 3'h4, 3'h5}) ? 8'h00 : 8'h5A;
			// Sync writes level 0, trigger 1, shorthand all.
			d = {12'h000, s ? 2'b10 : 2'(i), 2'b00, 1'b1, !s, 2'b00, i[0], m,
				8'h5A};
			wr(ics_pkg::ADDR_LOW, d);
			`CHK("src", 8'h21, ics_link_if_inst.msg.source)
			`CHK("valid", 1'b1, ics_link_if_inst.msg_valid)
			`CHK("mode", m, ics_link_if_inst.msg.mode)
			`CHK("vec", (m inside {3'h2, 3'h4, 3'h5}) ? 8'h00 : 8'h5A,
				ics_link_if_inst.msg.vector)
			`CHK("sh", s ? 2'b10 : 2'(i), ics_link_if_inst.msg.shorthand)
			`CHK("dest", s ? 8'hFF : 8'hAB, ics_link_if_inst.msg.dest)
			`CHK("dm", s ? 1'b0 : i[0], ics_link_if_inst.msg.dest_logical)
			`CHK("trig", s, ics_link_if_inst.msg.trigger)
			`CHK("busy", 1'b1, o_busy)
			@(posedge i_clock);
			#1;
			`CHK("pulse", PULSES[i], pulse)
			`CHK("ovec", v, o_vector)
			if (s) `CHK("arb", 8'h3C, o_arbitration_identifier)
			rd(ics_pkg::ADDR_LOW, (d & ics_pkg::LOW_WMASK) | 32'h00001000,
				"pend");
			w = 0;
			while (o_busy !== 1'b0 && w < 20) begin
				@(posedge i_clock);
				w++;
			end
			rd(ics_pkg::ADDR_LOW, d & ics_pkg::LOW_WMASK, "idle");
		end
		tally_and_finish();
	end
endmodule : tb_ipi_command_sender
`default_nettype wire
